// ==== hw/pot_link_pkg.sv ====
// Shared constants and types for the potentiometer serial frame port
package pot_link_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int WIPER_BITS = 10;
  localparam int NV_WORDS = 16;
  localparam logic [3:0] WIPER_POSITION_OFFSET = 4'h0;
  localparam logic [9:0] WIPER_MIDSCALE = 10'h200;
  localparam logic [15:0] NV_SLOT0_RESET = 16'h0200;
  localparam logic [15:0] NV_SLOT1_RESET = 16'h0003;
  // Store time in microseconds and its cycle count at 20 MHz
  localparam int STORE_TIME_US = 25000;
  localparam int CLK_MHZ = 20;
  localparam int STORE_CYCLES = STORE_TIME_US * CLK_MHZ;
  localparam int DONE_PULSE_CYCLES = 4;
  localparam int LINK_DIV = 4;
  // Host register offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_TXFRAME = 12'h004;
  localparam logic [11:0] REG_RXFRAME = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [11:0] REG_CONFIG = 12'h010;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_RESTORE = 4'h1, CMD_STORE_WIPER = 4'h2, CMD_STORE_DATA = 4'h3,
    CMD_DEC6_A = 4'h4, CMD_DEC6_B = 4'h5, CMD_DEC1_A = 4'h6, CMD_DEC1_B = 4'h7,
    CMD_RESET = 4'h8, CMD_READ_NV = 4'h9, CMD_READ_WIPER = 4'hA, CMD_WRITE_WIPER = 4'hB,
    CMD_INC6_A = 4'hC, CMD_INC6_B = 4'hD, CMD_INC1_A = 4'hE, CMD_INC1_B = 4'hF
  } command_field_t;
endpackage

// ==== hw/pot_link_if.sv ====
// Five-wire serial link between host and potentiometer
`timescale 1ns/1ps
interface pot_link_if;
  logic link_clk;
  logic chip_sel_n;
  logic serial_in;
  logic serial_out_o;
  logic serial_out_oe;
  logic store_done_n;
  // Open-drain line with an external pull-up
  wire serial_out_line = serial_out_oe ? serial_out_o : 1'b1;
  modport device (input link_clk, input chip_sel_n, input serial_in,
                  output serial_out_o, output serial_out_oe, output store_done_n);
  modport host (output link_clk, output chip_sel_n, output serial_in,
                input serial_out_line, input store_done_n);
endinterface

// ==== hw/pot_frame_device.sv ====
// Potentiometer end of the serial frame port
`timescale 1ns/1ps
// How it works
// - 24-bit frames shifted MSB first
// - Host keeps select low for whole frame
// - Act only on select rising
// - Command, address, data select operation
// - Command top nibble, address next nibble
// - Wiper uses 10 bits, store 16
// - Bit counter frames of 24
// - Bare select pulse repeats previous command
// - Count not multiple of 24 discards
// - Modes 0 and 3 both supported
// - Readback of wiper or stored word
// - Other commands pass bits down chain
// - Serial output open-drain
// - Chain of two needs 48 bits
// - Host holds select until chain loaded
// - Wiper loaded from store at power-on
// - Two latched outputs, default one
// - Output shifts last 24 bits, readback
// - Store 25 ms, locked, done pulses low
// - Command 11 writes wiper, 2 stores
module pot_frame_device
  import pot_link_pkg::*;
#(
  parameter int STORE_WAIT = pot_link_pkg::STORE_CYCLES
)(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Link
  pot_link_if.device link,
  // User side
  output logic [9:0] wiper_position_out,
  output logic latched_output_one_out,
  output logic latched_output_two_out,
  output logic busy_out
);
  import pot_link_pkg::*;
  initial
  begin
    if (STORE_WAIT < 1)
      $error("STORE_WAIT must be positive");
  end
  logic [2:0] clk_s, cs_s;
  logic [1:0] din_s;
  logic [23:0] shift_reg;
  logic [5:0] bit_cnt;
  logic edge_seen;
  logic [23:0] last_frame;
  logic last_valid;
  logic [9:0] wiper_position_register;
  logic [15:0] nonvolatile_store [NV_WORDS];
  logic [15:0] next_nv_word;
  logic powered;
  logic [31:0] store_cnt;
  logic [2:0] done_cnt;
  logic so_low;
  logic [3:0] store_addr;
  // Edges only from the second and third stages
  wire clk_rise = clk_s[1] & ~clk_s[2];
  wire clk_fall = ~clk_s[1] & clk_s[2];
  wire cs_rise = cs_s[1] & ~cs_s[2];
  wire cs_low = ~cs_s[1];
  wire storing = store_cnt != 32'h0;
  wire [3:0] cmd = shift_reg[CMD_MSB:CMD_LSB];
  wire [3:0] addr = shift_reg[ADDR_MSB:ADDR_LSB];
  wire [15:0] data = shift_reg[DATA_MSB:0];
  wire bare_pulse = cs_rise && !edge_seen && bit_cnt == 6'h0;
  wire whole_frame = cs_rise && edge_seen && bit_cnt == 6'h0;
  wire [23:0] exec_frame = bare_pulse ? last_frame : shift_reg;
  wire exec = !storing && ((whole_frame) || (bare_pulse && last_valid && powered));
  wire [3:0] ecmd = exec_frame[CMD_MSB:CMD_LSB];
  wire [3:0] eaddr = exec_frame[ADDR_MSB:ADDR_LSB];
  wire [15:0] edata = exec_frame[DATA_MSB:0];
  wire [9:0] w = wiper_position_register;
  wire [9:0] w_inc1 = (w == 10'h3FF) ? w : w + 10'h001;
  wire [9:0] w_dec1 = (w == 10'h000) ? w : w - 10'h001;
  wire [9:0] w_inc6 = w[9] ? 10'h3FF : {w[8:0], 1'b0};
  wire [9:0] w_dec6 = {1'b0, w[9:1]};
  logic [9:0] next_wiper;
  always_comb
  begin
    next_wiper = w;
    unique case (ecmd)
      CMD_RESTORE, CMD_RESET: next_wiper = nonvolatile_store[0][WIPER_BITS-1:0];
      CMD_WRITE_WIPER: next_wiper = (eaddr == WIPER_POSITION_OFFSET) ? edata[WIPER_BITS-1:0] : w;
      CMD_DEC6_A, CMD_DEC6_B: next_wiper = w_dec6;
      CMD_DEC1_A, CMD_DEC1_B: next_wiper = w_dec1;
      CMD_INC6_A, CMD_INC6_B: next_wiper = w_inc6;
      CMD_INC1_A, CMD_INC1_B: next_wiper = w_inc1;
      default: next_wiper = w;
    endcase
  end
  // Stored word for commands 2 and 3
  assign next_nv_word = (ecmd == CMD_STORE_WIPER) ? {6'h00, w} : edata;
  wire starts_store = exec && (ecmd == CMD_STORE_WIPER ||
                      (ecmd == CMD_STORE_DATA && eaddr != 4'h0));
  always_ff @(posedge ref_clk_in)
  begin
    clk_s <= {clk_s[1:0], link.link_clk};
    cs_s <= {cs_s[1:0], link.chip_sel_n};
    din_s <= {din_s[0], link.serial_in};
  end
  // Frame capture; shift register stays locked while storing
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      shift_reg <= 24'h000000;
      bit_cnt <= 6'h0;
      edge_seen <= 1'b0;
    end
    else if (cs_low && clk_rise && !storing)
    begin
      shift_reg <= {shift_reg[22:0], din_s[1]};
      bit_cnt <= (bit_cnt == 6'(FRAME_BITS - 1)) ? 6'h0 : bit_cnt + 6'h1;
      edge_seen <= 1'b1;
    end
    else if (cs_rise)
    begin
      bit_cnt <= 6'h0;
      edge_seen <= 1'b0;
      // Readback loads the requested word into the data bytes
      if (exec && ecmd == CMD_READ_WIPER)
        shift_reg <= {exec_frame[23:16], 6'h00, w};
      else if (exec && ecmd == CMD_READ_NV)
        shift_reg <= {exec_frame[23:16], nonvolatile_store[eaddr]};
    end
  end
  // A frame with a miscount is dropped rather than executed
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      wiper_position_register <= WIPER_MIDSCALE;
      powered <= 1'b0;
      last_frame <= 24'h000000;
      last_valid <= 1'b0;
      store_cnt <= 32'h0;
      done_cnt <= 3'h0;
      store_addr <= 4'h0;
      for (int i = 0; i < NV_WORDS; i++)
        nonvolatile_store[i] <= (i == 1) ? NV_SLOT1_RESET : ((i == 0) ? NV_SLOT0_RESET : 16'h0000);
    end
    else
    begin
      if (!powered)
      begin
        wiper_position_register <= nonvolatile_store[0][WIPER_BITS-1:0];
        powered <= 1'b1;
      end
      else if (exec)
        wiper_position_register <= next_wiper;
      if (whole_frame && !storing)
      begin
        last_frame <= shift_reg;
        last_valid <= 1'b1;
      end
      if (starts_store)
      begin
        store_cnt <= 32'(STORE_WAIT);
        store_addr <= (ecmd == CMD_STORE_WIPER) ? 4'h0 : eaddr;
        nonvolatile_store[(ecmd == CMD_STORE_WIPER) ? 4'h0 : eaddr] <= next_nv_word;
      end
      else if (storing)
      begin
        store_cnt <= store_cnt - 32'h1;
        if (store_cnt == 32'h1)
          done_cnt <= 3'(DONE_PULSE_CYCLES);
      end
      if (done_cnt != 3'h0)
        done_cnt <= done_cnt - 3'h1;
    end
  end
  // Output bit changes on the falling link edge
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      so_low <= 1'b0;
    else if (!cs_low)
      so_low <= 1'b0;
    else if (clk_fall || (cs_low && !edge_seen))
      so_low <= ~shift_reg[23];
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      link.serial_out_o <= 1'b0;
      link.serial_out_oe <= 1'b0;
      link.store_done_n <= 1'b1;
      wiper_position_out <= WIPER_MIDSCALE;
      latched_output_one_out <= 1'b1;
      latched_output_two_out <= 1'b1;
      busy_out <= 1'b0;
    end
    else
    begin
      link.serial_out_o <= 1'b0;
      link.serial_out_oe <= so_low && cs_low;
      link.store_done_n <= (done_cnt == 3'h0);
      wiper_position_out <= wiper_position_register;
      latched_output_one_out <= nonvolatile_store[1][0];
      latched_output_two_out <= nonvolatile_store[1][1];
      busy_out <= storing;
    end
  end
  wire unused_ok = ^{addr, data, store_addr};
endmodule

// ==== hw/pot_frame_host.sv ====
// Host end: APB-controlled master of the serial frame link
`timescale 1ns/1ps
module pot_frame_host
  import pot_link_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  pot_link_if.host link
);
  import pot_link_pkg::*;
  typedef enum logic [2:0] {H_IDLE = 3'b001, H_SHIFT = 3'b010, H_END = 3'b100} host_state_t;
  host_state_t state;
  logic [47:0] tx;
  logic [47:0] rx;
  logic [5:0] bits_left;
  logic [5:0] frame_len;
  logic [7:0] div;
  logic phase;
  logic busy;
  logic [1:0] so_s, done_s;
  logic done_seen;
  wire tick = div == 8'(LINK_DIV - 1);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  // Writes land at the edge where pready is seen high, as the master expects
  wire wr_take = wr && pready;
  wire go = wr && paddr == REG_CTRL && pwdata[0] && !busy;
  wire known = paddr == REG_CTRL || paddr == REG_TXFRAME || paddr == REG_RXFRAME ||
               paddr == REG_STATUS || paddr == REG_CONFIG;
  always_ff @(posedge ref_clk_in)
  begin
    so_s <= {so_s[0], link.serial_out_line};
    done_s <= {done_s[0], link.store_done_n};
  end
  // Frame length 0 gives a bare select pulse, otherwise frame_len bits (24 after reset)
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      state <= H_IDLE;
      tx <= 48'h0;
      rx <= 48'h0;
      bits_left <= 6'h0;
      frame_len <= 6'd24;
      div <= 8'h0;
      phase <= 1'b0;
      busy <= 1'b0;
      done_seen <= 1'b0;
      link.link_clk <= 1'b0;
      link.chip_sel_n <= 1'b1;
      link.serial_in <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !known;
      if (!done_s[1])
        done_seen <= 1'b1;
      if (acc && !pready && !pwrite)
        prdata <= (paddr == REG_RXFRAME) ? {8'h00, rx[23:0]} :
                  (paddr == REG_STATUS) ? {30'h0, done_seen, busy} :
                  (paddr == REG_CONFIG) ? {26'h0, frame_len} :
                  (paddr == REG_TXFRAME) ? tx[31:0] : 32'h0;
      if (wr_take && !busy && paddr == REG_TXFRAME)
        tx <= {tx[23:0], pwdata[23:0]};
      if (wr_take && !busy && paddr == REG_CONFIG)
        frame_len <= pwdata[5:0];
      if (wr_take && paddr == REG_STATUS && pwdata[1])
        done_seen <= 1'b0;
      div <= tick ? 8'h0 : div + 8'h1;
      unique case (state)
        H_IDLE:
          if (go && pready)
          begin
            busy <= 1'b1;
            // Restart the divider so the first rise leaves time for the reply bit
            div <= 8'h0;
            link.chip_sel_n <= 1'b0;
            bits_left <= frame_len;
            link.serial_in <= (frame_len == 6'h0) ? 1'b0 : tx[6'(frame_len - 6'h1)];
            phase <= 1'b0;
            state <= (frame_len == 6'h0) ? H_END : H_SHIFT;
          end
        H_SHIFT:
          if (tick)
          begin
            phase <= ~phase;
            if (!phase)
            begin
              link.link_clk <= 1'b1;
              bits_left <= bits_left - 6'h1;
            end
            else
            begin
              // Reply bit is taken late: both synchronisers delay it past the rise
              rx <= {rx[46:0], so_s[1]};
              link.link_clk <= 1'b0;
              if (bits_left == 6'h0)
                state <= H_END;
              else
                link.serial_in <= tx[6'(bits_left - 6'h1)];
            end
          end
        H_END:
          if (tick)
          begin
            link.chip_sel_n <= 1'b1;
            busy <= 1'b0;
            state <= H_IDLE;
          end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule

// ==== bench/pot_link_properties.sv ====
// Concurrent checks on the serial frame link between host and device
`timescale 1ns/1ps
module pot_link_properties #(
  parameter int STORE_WAIT = 50
)(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Link signals
  input wire logic link_clk,
  input wire logic chip_sel_n,
  input wire logic serial_in,
  input wire logic serial_out_o,
  input wire logic serial_out_oe,
  input wire logic store_done_n
);
  logic [5:0] rises;
  logic [19:0] high_cnt;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  // Link clock rises seen inside the current frame
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in || chip_sel_n) rises <= 6'h00;
    else if ($rose(link_clk)) rises <= rises + 6'h01;
  end

  // Saturating count of cycles with the done line high
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in || !store_done_n) high_cnt <= 20'h00000;
    else if (high_cnt != 20'hFFFFF) high_cnt <= high_cnt + 20'h00001;
  end

  sequence high_phase;
    link_clk [*4] ##1 !link_clk;
  endsequence
  sequence done_pulse;
    !store_done_n [*4] ##1 store_done_n;
  endsequence

  a_drain_only: assert property (serial_out_oe |-> !serial_out_o)
    else $error("serial output driven high");
  a_release_idle: assert property (chip_sel_n [*4] |-> !serial_out_oe)
    else $error("serial output held while deselected");
  a_clock_idle: assert property (chip_sel_n [*8] |-> !link_clk)
    else $error("link clock not idle low");
  a_high_phase: assert property ($rose(link_clk) |-> high_phase)
    else $error("link clock high phase wrong");
  a_low_phase: assert property ($fell(link_clk) |-> !link_clk [*4])
    else $error("link clock low phase short");
  a_data_steady: assert property ($rose(link_clk) |-> $stable(serial_in))
    else $error("serial input moved at sampling edge");
  a_out_steady: assert property (($rose(link_clk) && !chip_sel_n) |=> ##1 (chip_sel_n || $stable(serial_out_oe)) [*2])
    else $error("serial output moved in clock high phase");
  a_frame_length: assert property ($rose(chip_sel_n) |-> (rises == 6'h00 || rises == 6'h18 || rises == 6'h30))
    else $error("frame not a whole number of words");
  a_done_pulse: assert property ($fell(store_done_n) |-> done_pulse)
    else $error("store done pulse length wrong");
  a_store_time: assert property ($fell(store_done_n) |-> high_cnt >= STORE_WAIT)
    else $error("store finished too early");
endmodule

// ==== bench/potentiometer_serial_frame_port_test.sv ====
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module potentiometer_serial_frame_port_test;
  import pot_link_pkg::*;
  // Long enough that a whole frame fits inside one store
  localparam int STORE_W = 400;
  typedef struct packed {logic [23:0] tx; logic [9:0] wiper; logic [1:0] mode; logic [23:0] rx;} row_t;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] wiper;
  logic lo1;
  logic lo2;
  logic busy;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int checked = 0;
  // Mode 0: no readback check, 1: data bytes only, 2: whole frame
  row_t rows [17] = '{
    {24'hB0FD55, 10'h155, 2'h0, 24'h000000}, {24'hE00000, 10'h156, 2'h2, 24'hB0FD55},
    {24'h600000, 10'h155, 2'h2, 24'hE00000}, {24'hC00000, 10'h2AA, 2'h2, 24'h600000},
    {24'hD00000, 10'h3FF, 2'h2, 24'hC00000}, {24'h400000, 10'h1FF, 2'h2, 24'hD00000},
    {24'h500000, 10'h0FF, 2'h2, 24'h400000}, {24'h700000, 10'h0FE, 2'h2, 24'h500000},
    {24'hF00000, 10'h0FF, 2'h2, 24'h700000}, {24'hA00000, 10'h0FF, 2'h2, 24'hF00000},
    {24'h000000, 10'h0FF, 2'h1, 24'h0000FF}, {24'h100000, 10'h200, 2'h2, 24'h000000},
    {24'hB00000, 10'h000, 2'h2, 24'h100000}, {24'h600000, 10'h000, 2'h2, 24'hB00000},
    {24'h800000, 10'h200, 2'h2, 24'h600000}, {24'h900000, 10'h200, 2'h2, 24'h800000},
    {24'h000000, 10'h200, 2'h1, 24'h000200}};

  pot_link_if lnk ();
  pot_frame_host pot_frame_host_i (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(lnk));
  pot_frame_device #(.STORE_WAIT(STORE_W)) pot_frame_device_i (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .link(lnk), .wiper_position_out(wiper), .latched_output_one_out(lo1), .latched_output_two_out(lo2),
    .busy_out(busy));
  pot_link_properties #(.STORE_WAIT(STORE_W)) pot_link_properties_i (.ref_clk_in(ref_clk_in),
    .srst_in(srst_in), .link_clk(lnk.link_clk), .chip_sel_n(lnk.chip_sel_n), .serial_in(lnk.serial_in),
    .serial_out_o(lnk.serial_out_o), .serial_out_oe(lnk.serial_out_oe), .store_done_n(lnk.store_done_n));

  initial
  begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge; answer taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    @(posedge ref_clk_in);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 50)
      failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go();
    int n;
    n = 0;
    apb(1'b1, REG_CTRL, 32'h00000001);
    rd = 32'h00000001;
    while (rd[0] !== 1'b0 && n < 100)
    begin
      apb(1'b0, REG_STATUS, 32'h00000000);
      n++;
    end
    if (n >= 100)
      failures++;
    repeat (10) @(posedge ref_clk_in);
  endtask

  task automatic send(input logic [23:0] tx);
    apb(1'b1, REG_TXFRAME, {8'h00, tx});
    go();
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk_in);
    failures++;
    summarize();
  end

  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    repeat (10) @(posedge ref_clk_in);
    cmp(wiper, WIPER_MIDSCALE);
    cmp({lo1, lo2}, 2'b11);
    foreach (rows[i])
    begin
      send(rows[i].tx);
      cmp(wiper, rows[i].wiper);
      apb(1'b0, REG_RXFRAME, 32'h00000000);
      if (rows[i].mode == 2'h1)
        cmp(rd[15:0], rows[i].rx[15:0]);
      else if (rows[i].mode == 2'h2)
        cmp(rd[23:0], rows[i].rx);
    end
    // A frame sent mid-store must be ignored
    send(24'hB000AB);
    send(24'h200000);
    cmp(busy, 1'b1);
    send(24'hB00011);
    cmp(wiper, 10'h0AB);
    repeat (STORE_W) @(posedge ref_clk_in);
    apb(1'b0, REG_STATUS, 32'h00000000);
    cmp(rd[1], 1'b1);
    apb(1'b1, REG_STATUS, 32'h00000002);
    send(24'hB00000);
    send(24'h100000);
    cmp(wiper, 10'h0AB);
    send(24'h310000);
    repeat (STORE_W + 20) @(posedge ref_clk_in);
    cmp({lo1, lo2}, 2'b00);
    send(24'hE00000);
    apb(1'b1, REG_CONFIG, 32'h00000000);
    go();
    cmp(wiper, 10'h0AD);
    apb(1'b1, REG_CONFIG, 32'h00000030);
    apb(1'b1, REG_TXFRAME, 32'h00E00000);
    send(24'hB00123);
    cmp(wiper, 10'h123);
    apb(1'b0, REG_RXFRAME, 32'h00000000);
    cmp(rd[23:0], 24'hE00000);
    apb(1'b0, 12'h020, 32'h00000000);
    cmp(err, 1'b1);
    summarize();
  end
endmodule
